// ---- bench/ide_link_sva.sv ----
// Checker for the disk port: request handshake, acknowledge and selects.
// Assumes one clock; placed beside the link interface by the testbench.
`timescale 1ns/1ps
`default_nettype none

module ide_link_sva (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Host driven pins
    input wire logic [2:0] addr,
    input wire logic taskfile_select_n,
    input wire logic control_block_select_n,
    input wire logic io_read_strobe_n,
    input wire logic dma_acknowledge_n,
    // Device driven pins
    input wire logic [15:0] dev_data_out,
    input wire logic dev_data_oe_n,
    input wire logic dma_request,
    input wire logic input_ack_n,
    input wire logic input_ack_oe_n
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // ====================
    // Request handshake
    chk_req_hold: assert property (dma_request && dma_acknowledge_n |=> dma_request)
        else $error("request dropped before acknowledge");
    chk_req_release: assert property ($fell(dma_acknowledge_n) |-> ##[0:2] !dma_request)
        else $error("request kept after acknowledge");
    chk_req_rerise: assert property ($rose(dma_request) |-> dma_acknowledge_n)
        else $error("request raised during acknowledge");
    chk_dma_no_select: assert property (!dma_acknowledge_n |->
        taskfile_select_n && control_block_select_n)
        else $error("select active during acknowledge");
    chk_dma_read_drive: assert property (!dma_acknowledge_n && !io_read_strobe_n
        |-> !dev_data_oe_n)
        else $error("device silent on dma read");

    // ====================
    // Input acknowledge and register width
    chk_ack_only_read: assert property (!input_ack_oe_n && !input_ack_n
        |-> !io_read_strobe_n && !taskfile_select_n)
        else $error("input acknowledge without read");
    chk_read_gets_ack: assert property (!input_ack_oe_n && !io_read_strobe_n
        && !taskfile_select_n |-> !input_ack_n)
        else $error("read not acknowledged");
    chk_reg_low_byte: assert property (!taskfile_select_n && !dev_data_oe_n
        && addr != 3'h0 |-> dev_data_out[15:8] == 8'h00)
        else $error("register uses high byte");

    // Main scenarios reached
    cover property ($fell(dma_acknowledge_n));
    cover property (!input_ack_oe_n && !input_ack_n);
    cover property (!control_block_select_n && !io_read_strobe_n);
endmodule : ide_link_sva

`default_nettype wire

// ---- bench/test_ide_host_dma_handshake.sv ----
// Testbench joining host end and device end of the disk port.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_ide_host_dma_handshake;
    logic CORE_CLK, RST_N, DEVICE_SELECTED, DMA_START, DMA_TO_HOST, TX_VALID, RX_READY;
    logic CMD_VALID, CMD_CONTROL, CMD_TO_HOST, DMA_WVALID, ack_seen;
    logic BUSY, COMMAND_STROBE, TX_READY, RX_VALID, CMD_READY, DMA_WREADY, RDATA_VALID, DONE;
    logic [2:0] CMD_ADDR;
    logic [7:0] COMMAND_CODE;
    logic [15:0] DMA_WORDS, TX_DATA, CMD_WDATA, CMD_WORDS, DMA_WDATA, RX_DATA, RDATA;
    logic [15:0] rq[$], rxq[$];
    ide_link_pkg::mode_t MODE;
    ide_link_pkg::host_cmd_t CMD_KIND;
    int n_mismatch = 0;
    int samples_checked = 0;

    // ====================
    // Both ends and the checker
    ide_link_if lk();
    ide_device_end u_ide_device_end (.CORE_CLK, .RST_N, .link(lk), .MODE, .DEVICE_SELECTED,
        .DMA_START, .DMA_WORDS, .DMA_TO_HOST, .BUSY, .COMMAND_STROBE, .COMMAND_CODE,
        .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA, .RX_VALID, .RX_READY);
    ide_host_end u_ide_host_end (.CORE_CLK, .RST_N, .link(lk), .CMD_VALID, .CMD_READY,
        .CMD_KIND, .CMD_CONTROL, .CMD_ADDR, .CMD_WDATA, .CMD_WORDS, .CMD_TO_HOST,
        .DMA_WDATA, .DMA_WVALID, .DMA_WREADY, .RDATA, .RDATA_VALID, .DONE);
    ide_link_sva u_ide_link_sva (.CORE_CLK, .RST_N, .addr(lk.addr),
        .taskfile_select_n(lk.taskfile_select_n),
        .control_block_select_n(lk.control_block_select_n),
        .io_read_strobe_n(lk.io_read_strobe_n), .dma_acknowledge_n(lk.dma_acknowledge_n),
        .dev_data_out(lk.dev_data_out), .dev_data_oe_n(lk.dev_data_oe_n),
        .dma_request(lk.dma_request), .input_ack_n(lk.input_ack_n),
        .input_ack_oe_n(lk.input_ack_oe_n));

    // ====================
    // Clock and monitors
    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        if (RDATA_VALID) rq.push_back(RDATA);
        if (RX_VALID) rxq.push_back(RX_DATA);
        if (DMA_WREADY) DMA_WDATA <= DMA_WDATA + 16'h0001;
        if (!lk.input_ack_line) ack_seen = 1'b1;
    end

    // ====================
    // Tasks
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic cmd(input ide_link_pkg::host_cmd_t k, input logic c, input logic [2:0] a,
        input logic [15:0] d, input logic [15:0] n, input logic th);
        {CMD_KIND, CMD_CONTROL, CMD_ADDR, CMD_WDATA, CMD_WORDS, CMD_TO_HOST} = {k, c, a, d, n, th};
        CMD_VALID = 1'b1;
        @(posedge CORE_CLK iff CMD_READY);
        #1 CMD_VALID = 1'b0;
        @(posedge CORE_CLK iff DONE);
        #1;
    endtask : cmd
    // Device core side: one DMA command with its word count
    task automatic start(input logic th, input logic [15:0] n);
        {DMA_TO_HOST, DMA_WORDS, DMA_START} = {th, n, 1'b1};
        @(posedge CORE_CLK);
        #1 DMA_START = 1'b0;
    endtask : start
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Hang guard, far beyond the tests
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end

    // ====================
    // Test sequence
    initial begin
        {RST_N, DMA_START, TX_VALID, CMD_VALID, DMA_WVALID, ack_seen} = '0;
        {DEVICE_SELECTED, RX_READY, DMA_TO_HOST, CMD_CONTROL, CMD_TO_HOST} = 5'h18;
        {DMA_WORDS, TX_DATA, CMD_WDATA, CMD_WORDS, CMD_ADDR} = '0;
        DMA_WDATA = 16'h2220;
        MODE = ide_link_pkg::MODE_IDE;
        CMD_KIND = ide_link_pkg::CMD_REG_READ;
        repeat (3) @(posedge CORE_CLK);
        #1 RST_N = 1'b1;
        cmd(ide_link_pkg::CMD_REG_READ, 1'b0, 3'h7, 16'h0000, 16'h0000, 1'b0);
        chk(RDATA, 16'h0040);
        cmd(ide_link_pkg::CMD_REG_READ, 1'b1, 3'h6, 16'h0000, 16'h0000, 1'b0);
        chk(RDATA, 16'h0040);
        cmd(ide_link_pkg::CMD_REG_WRITE, 1'b0, 3'h7, 16'h00c8, 16'h0000, 1'b0);
        chk({8'h00, COMMAND_CODE}, 16'h00c8);
        $display("test registers done");
        // Words wait in the buffer so the request is held before the host answers
        start(1'b1, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            {TX_DATA, TX_VALID} = {16'h1110 + 16'(i), 1'b1};
            @(posedge CORE_CLK iff TX_READY);
            #1 TX_VALID = 1'b0;
        end
        rq.delete();
        cmd(ide_link_pkg::CMD_DMA, 1'b0, 3'h0, 16'h0000, 16'h0003, 1'b1);
        chk(16'(rq.size()), 16'h0003);
        foreach (rq[i]) chk(rq[i], 16'h1110 + 16'(i));
        chk({15'h0000, lk.dma_request_line}, 16'h0000);
        $display("test dma to host done");
        start(1'b0, 16'h0002);
        DMA_WVALID = 1'b1;
        cmd(ide_link_pkg::CMD_DMA, 1'b0, 3'h0, 16'h0000, 16'h0002, 1'b0);
        DMA_WVALID = 1'b0;
        if (rxq.size() < 2) @(posedge CORE_CLK iff rxq.size() == 2);
        chk(rxq[0], 16'h2220);
        chk(rxq[1], 16'h2221);
        $display("test dma from host done");
        MODE = ide_link_pkg::MODE_IO;
        ack_seen = 1'b0;
        cmd(ide_link_pkg::CMD_REG_READ, 1'b0, 3'h7, 16'h0000, 16'h0000, 1'b0);
        chk(RDATA, 16'h0040);
        chk(16'(ack_seen), 16'h0001);
        MODE = ide_link_pkg::MODE_MEMORY;
        ack_seen = 1'b0;
        cmd(ide_link_pkg::CMD_REG_READ, 1'b0, 3'h7, 16'h0000, 16'h0000, 1'b0);
        chk(RDATA, 16'h0000);
        chk(16'(ack_seen), 16'h0000);
        $display("test modes done");
        end_sim();
    end
endmodule : test_ide_host_dma_handshake

`default_nettype wire

// ---- rtl/ide_device_end.sv ----
// Device end of the parallel disk port: task-file registers, I/O acknowledge
// and the multiword DMA request/acknowledge handshake with a 4-word FIFO.
// Assumes link pins are synchronous to CORE_CLK and the host holds selects
// and acknowledge for one cycle after each strobe's trailing edge.
`timescale 1ns/1ps
`default_nettype none
`include "ide_link_map.svh"

// Overview of operation
// R1 - Registers on low byte, data full word
// R2 - Input acknowledge only for selected reads
// R3 - Memory mode ignores I/O read strobe
// R4 - Request DMA when ready to move data
// R5 - Strobe kind sets transfer direction
// R6 - Hold request until acknowledge arrives
// R7 - Re-request while words remain
// R8 - Request line undriven when not selected
// R9 - DMA keeps selects negated, sixteen bits
// R10 - Host without DMA never attempts it
// R11 - First select task file, second control
// R12 - No request after final word
module ide_device_end (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Link pins
    ide_link_if.device link,
    // Configuration
    input wire ide_link_pkg::mode_t MODE,
    input wire logic DEVICE_SELECTED,
    // DMA command from the device core
    input wire logic DMA_START,
    input wire logic [15:0] DMA_WORDS,
    input wire logic DMA_TO_HOST,
    output logic BUSY,
    // Command register written by the host
    output logic COMMAND_STROBE,
    output logic [7:0] COMMAND_CODE,
    // Words going to the host
    input wire logic [15:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    // Words coming from the host
    output logic [15:0] RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY
);
    typedef struct packed {
        ide_link_pkg::dev_state_t st;
        logic [15:0] words;
        logic to_host;
        logic rd_low;
        logic wr_low;
        logic [15:0] wdata;
        logic [7:0][7:0] tf;
        logic [7:0] ctrl;
        logic cmd_pulse;
        logic [7:0] cmd_code;
    } dev_reg_t;

    dev_reg_t q, d;

    logic io_mode, ide_mode, rd_now, wr_now, rd_end, wr_end, dma_acc;
    logic sel_tf, sel_cb, data_acc, xfer_ready;
    logic [7:0] status, reg_byte;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [15:0] fifo_in_data, fifo_out_data;

    // A strobe ends on its low-to-high edge; the word is taken then
    function automatic logic strobe_end(input logic was_low, input logic now_n);
        return was_low & now_n;
    endfunction : strobe_end

    // ====================
    // Access decode
    assign io_mode = MODE == ide_link_pkg::MODE_IO;
    assign ide_mode = MODE == ide_link_pkg::MODE_IDE;
    // Memory mode has no I/O cycles, so both strobes are ignored there
    assign rd_now = ~link.io_read_strobe_n & (io_mode | ide_mode); // R3
    assign wr_now = ~link.io_write_strobe_n & (io_mode | ide_mode);
    assign rd_end = strobe_end(q.rd_low, link.io_read_strobe_n) & (io_mode | ide_mode);
    assign wr_end = strobe_end(q.wr_low, link.io_write_strobe_n) & (io_mode | ide_mode);
    // Under acknowledge the selects are negated, every move is a word
    assign dma_acc = ide_mode & DEVICE_SELECTED & ~link.dma_acknowledge_n; // R9
    assign sel_tf = ~dma_acc & ~link.taskfile_select_n &
                    (io_mode | (ide_mode & DEVICE_SELECTED)); // R11
    assign sel_cb = ~dma_acc & ide_mode & DEVICE_SELECTED &
                    ~link.control_block_select_n; // R11
    assign data_acc = dma_acc | (sel_tf & (link.addr == `ADDR_DATA));
    // Room to take a word, or a word to give
    assign xfer_ready = q.to_host ? fifo_out_valid : fifo_in_ready;

    // ====================
    // Status and register read byte
    always_comb begin
        status = 8'h00;
        status[`STATUS_READY_BIT] = 1'b1;
        status[`STATUS_DRQ_BIT] = q.st != ide_link_pkg::D_IDLE;
        if (sel_cb) begin
            reg_byte = (link.addr == `ADDR_CONTROL) ? status : 8'h00;
        end else if (link.addr == `ADDR_STATUS) begin
            reg_byte = status;
        end else begin
            reg_byte = q.tf[link.addr];
        end
    end

    // ====================
    // Data lanes: words for data, low byte only for registers
    assign link.dev_data_out = data_acc ? fifo_out_data : {8'h00, reg_byte}; // R1
    assign link.dev_data_oe_n = ~(rd_now & (data_acc | sel_tf | sel_cb)); // R5

    // Input acknowledge answers selected I/O reads only; idle outside I/O mode
    assign link.input_ack_n = ~(io_mode & sel_tf & rd_now); // R2
    assign link.input_ack_oe_n = ~io_mode; // R3

    // Request is driven only while this device is selected
    assign link.dma_request = q.st == ide_link_pkg::D_REQ; // R6
    assign link.dma_request_oe_n = ~(ide_mode & DEVICE_SELECTED); // R8

    // ====================
    // FIFO steering: direction is fixed by the last DMA command
    always_comb begin
        if (q.to_host) begin
            fifo_in_data = TX_DATA;
            fifo_in_valid = TX_VALID;
            fifo_out_ready = rd_end & data_acc; // R5
        end else begin
            fifo_in_data = q.wdata;
            fifo_in_valid = wr_end & data_acc; // R5
            fifo_out_ready = RX_READY;
        end
    end

    assign TX_READY = q.to_host & fifo_in_ready;
    assign RX_VALID = ~q.to_host & fifo_out_valid;
    assign RX_DATA = fifo_out_data;
    assign BUSY = q.st != ide_link_pkg::D_IDLE;
    assign COMMAND_STROBE = q.cmd_pulse;
    assign COMMAND_CODE = q.cmd_code;

    word_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .in_data(fifo_in_data),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    // ====================
    // Next state: register writes, strobe tracking and the DMA handshake
    always_comb begin
        d = q;
        d.cmd_pulse = 1'b0;
        d.rd_low = rd_now;
        d.wr_low = wr_now;
        // Latch the bus while the write strobe is low; used at its end
        if (wr_now) begin
            d.wdata = link.data_bus;
        end
        // Register writes take the low byte only
        if (wr_end & sel_tf & (link.addr != `ADDR_DATA)) begin
            d.tf[link.addr] = q.wdata[7:0]; // R1
            if (link.addr == `ADDR_COMMAND) begin
                d.cmd_pulse = 1'b1;
                d.cmd_code = q.wdata[7:0];
            end
        end
        if (wr_end & sel_cb & (link.addr == `ADDR_CONTROL)) begin
            d.ctrl = q.wdata[7:0];
        end
        case (q.st)
            ide_link_pkg::D_IDLE: begin
                if (DMA_START && DMA_WORDS != 16'h0000) begin
                    d.words = DMA_WORDS;
                    d.to_host = DMA_TO_HOST;
                    d.st = ide_link_pkg::D_WAIT;
                end
            end
            ide_link_pkg::D_WAIT: begin
                if (q.words == 16'h0000) begin
                    d.st = ide_link_pkg::D_IDLE; // R12
                end else if (xfer_ready) begin
                    d.st = ide_link_pkg::D_REQ; // R4
                end
            end
            ide_link_pkg::D_REQ: begin
                // Drop the request only once acknowledge is seen
                if (dma_acc) begin
                    d.st = ide_link_pkg::D_ACK; // R6
                end
            end
            ide_link_pkg::D_ACK: begin
                if (data_acc & (rd_end | wr_end) & (q.words != 16'h0000)) begin
                    d.words = q.words - 16'h0001;
                end
                if (!dma_acc) begin
                    d.st = (q.words == 16'h0000) ? ide_link_pkg::D_IDLE // R12
                                                 : ide_link_pkg::D_WAIT; // R7
                end
            end
            default: begin
                d.st = ide_link_pkg::D_IDLE;
            end
        endcase
        // Software reset through device control abandons any DMA
        if (q.ctrl[`CTRL_SRST_BIT]) begin
            d.st = ide_link_pkg::D_IDLE;
            d.words = 16'h0000;
        end
    end

    // ====================
    // State register
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            q <= '0;
            q.tf <= {8{`TF_RESET}};
            q.ctrl <= `CTRL_RESET;
        end else begin
            q <= d;
        end
    end
endmodule : ide_device_end

`default_nettype wire

// ---- rtl/ide_host_end.sv ----
// Host end of the parallel disk port: register reads and writes through
// the two selects and multiword DMA answering the device's request.
// Assumes the device answers within one strobe width of STROBE_CYC cycles.
`timescale 1ns/1ps
`default_nettype none
`include "ide_link_map.svh"

module ide_host_end #(
    parameter bit HAS_DMA = 1'b1
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Link pins
    ide_link_if.host link,
    // Command port
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire ide_link_pkg::host_cmd_t CMD_KIND,
    input wire logic CMD_CONTROL,
    input wire logic [2:0] CMD_ADDR,
    input wire logic [15:0] CMD_WDATA,
    input wire logic [15:0] CMD_WORDS,
    input wire logic CMD_TO_HOST,
    // Words to send during DMA writes
    input wire logic [15:0] DMA_WDATA,
    input wire logic DMA_WVALID,
    output logic DMA_WREADY,
    // Results
    output logic [15:0] RDATA,
    output logic RDATA_VALID,
    output logic DONE
);
    typedef struct packed {
        ide_link_pkg::host_state_t st;
        logic [3:0] cnt;
        logic [15:0] words;
        logic to_host;
        logic is_read;
        logic ack_n;
        logic rd_n;
        logic wr_n;
        logic cs0_n;
        logic cs1_n;
        logic [2:0] addr;
        logic [15:0] wdata;
        logic oe_n;
        logic [15:0] rdata;
        logic rvalid;
        logic done;
    } host_reg_t;

    host_reg_t q, d;
    logic take_word;

    // ====================
    // Pins straight from flops
    assign link.addr = q.addr;
    assign link.taskfile_select_n = q.cs0_n;
    assign link.control_block_select_n = q.cs1_n;
    assign link.io_read_strobe_n = q.rd_n;
    assign link.io_write_strobe_n = q.wr_n;
    assign link.dma_acknowledge_n = q.ack_n;
    assign link.host_data_out = q.wdata;
    assign link.host_data_oe_n = q.oe_n;
    assign CMD_READY = q.st == ide_link_pkg::H_IDLE;
    assign RDATA = q.rdata;
    assign RDATA_VALID = q.rvalid;
    assign DONE = q.done;
    // A write word is taken only when the device asks for one
    assign take_word = (q.st == ide_link_pkg::H_DMA_WAIT) & link.dma_request_line &
                       ~q.to_host & (q.words != 16'h0000);
    assign DMA_WREADY = take_word;

    // ====================
    // Next state
    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        d.done = 1'b0;
        case (q.st)
            ide_link_pkg::H_IDLE: begin
                if (CMD_VALID) begin
                    if (CMD_KIND == ide_link_pkg::CMD_DMA) begin
                        // Without DMA hardware the command completes at once
                        if (HAS_DMA && CMD_WORDS != 16'h0000) begin // R10
                            d.words = CMD_WORDS;
                            d.to_host = CMD_TO_HOST;
                            d.st = ide_link_pkg::H_DMA_WAIT;
                        end else begin
                            d.done = 1'b1;
                        end
                    end else begin
                        d.is_read = CMD_KIND == ide_link_pkg::CMD_REG_READ;
                        d.cs0_n = CMD_CONTROL; // R11
                        d.cs1_n = ~CMD_CONTROL; // R11
                        d.addr = CMD_ADDR;
                        d.wdata = CMD_WDATA;
                        d.st = ide_link_pkg::H_SETUP;
                    end
                end
            end
            ide_link_pkg::H_SETUP, ide_link_pkg::H_DMA_SETUP: begin
                d.rd_n = ~q.is_read; // R5
                d.wr_n = q.is_read; // R5
                d.oe_n = q.is_read;
                d.cnt = 4'(`STROBE_CYC - 1);
                d.st = (q.st == ide_link_pkg::H_SETUP) ? ide_link_pkg::H_STROBE
                                                       : ide_link_pkg::H_DMA_STROBE;
            end
            ide_link_pkg::H_STROBE, ide_link_pkg::H_DMA_STROBE: begin
                if (q.cnt == 4'h0) begin
                    d.rd_n = 1'b1;
                    d.wr_n = 1'b1;
                    if (q.is_read) begin
                        d.rdata = link.data_bus;
                        d.rvalid = 1'b1;
                    end
                    if (q.st == ide_link_pkg::H_STROBE) begin
                        d.st = ide_link_pkg::H_HOLD;
                    end else begin
                        d.words = q.words - 16'h0001;
                        d.st = ide_link_pkg::H_DMA_HOLD;
                    end
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            ide_link_pkg::H_HOLD: begin
                d.cs0_n = 1'b1;
                d.cs1_n = 1'b1;
                d.oe_n = 1'b1;
                d.done = 1'b1;
                d.st = ide_link_pkg::H_IDLE;
            end
            ide_link_pkg::H_DMA_WAIT: begin
                if (q.words == 16'h0000) begin
                    d.done = 1'b1;
                    d.st = ide_link_pkg::H_IDLE;
                end else if (link.dma_request_line && (q.to_host || DMA_WVALID)) begin
                    // Acknowledge with both selects negated
                    d.ack_n = 1'b0;
                    d.cs0_n = 1'b1; // R9
                    d.cs1_n = 1'b1; // R9
                    d.is_read = q.to_host;
                    if (take_word) begin
                        d.wdata = DMA_WDATA;
                    end
                    d.st = ide_link_pkg::H_DMA_SETUP;
                end
            end
            ide_link_pkg::H_DMA_HOLD: begin
                d.ack_n = 1'b1;
                d.oe_n = 1'b1;
                d.st = ide_link_pkg::H_DMA_WAIT;
            end
            default: begin
                d.st = ide_link_pkg::H_IDLE;
            end
        endcase
    end

    // ====================
    // State register; all pin strobes idle high
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            q <= '0;
            q.ack_n <= 1'b1;
            q.rd_n <= 1'b1;
            q.wr_n <= 1'b1;
            q.cs0_n <= 1'b1;
            q.cs1_n <= 1'b1;
            q.oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule : ide_host_end

`default_nettype wire

// ---- rtl/ide_link_if.sv ----
// Pin bundle between the disk device end and the host end.
// Assumes both ends run on one clock; resolves shared lines from the enables.
`timescale 1ns/1ps
`default_nettype none

interface ide_link_if;
    // ============================================================
    // Host driven pins
    logic [2:0] addr;
    logic taskfile_select_n;
    logic control_block_select_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic dma_acknowledge_n;
    logic [15:0] host_data_out;
    logic host_data_oe_n;
    // ============================================================
    // Device driven pins
    logic [15:0] dev_data_out;
    logic dev_data_oe_n;
    logic dma_request;
    logic dma_request_oe_n;
    logic input_ack_n;
    logic input_ack_oe_n;
    // ============================================================
    // Resolved lines; undriven request pulls low, acknowledge pulls high
    wire logic [15:0] data_bus;
    wire logic dma_request_line;
    wire logic input_ack_line;

    assign data_bus = !dev_data_oe_n ? dev_data_out :
                      (!host_data_oe_n ? host_data_out : 16'h0000);
    assign dma_request_line = !dma_request_oe_n & dma_request;
    assign input_ack_line = input_ack_oe_n ? 1'b1 : input_ack_n;

    modport device (
        input addr, taskfile_select_n, control_block_select_n,
        input io_read_strobe_n, io_write_strobe_n, dma_acknowledge_n, data_bus,
        output dev_data_out, dev_data_oe_n, dma_request, dma_request_oe_n,
        output input_ack_n, input_ack_oe_n
    );
    modport host (
        output addr, taskfile_select_n, control_block_select_n,
        output io_read_strobe_n, io_write_strobe_n, dma_acknowledge_n,
        output host_data_out, host_data_oe_n,
        input data_bus, dma_request_line, input_ack_line
    );
endinterface : ide_link_if

`default_nettype wire

// ---- rtl/ide_link_map.svh ----
// Offsets, field positions, reset values and timing counts of the disk port.
// Assumes the 50 MHz core clock; included by both ends of the link.
`ifndef IDE_LINK_MAP_SVH
`define IDE_LINK_MAP_SVH

// ====================
// Clock and strobe timing
`define CLK_PERIOD_NS 20
`define STROBE_NS 80
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ====================
// Data path sizes
`define DATA_W 16
`define FIFO_DEPTH 4

// ====================
// Register addresses within each select
`define ADDR_DATA 3'h0
`define ADDR_COMMAND 3'h7
`define ADDR_STATUS 3'h7
`define ADDR_CONTROL 3'h6

// ====================
// Field positions and reset values
`define STATUS_READY_BIT 6
`define STATUS_DRQ_BIT 3
`define CTRL_SRST_BIT 2
`define TF_RESET 8'h00
`define CTRL_RESET 8'h00

`endif

// ---- rtl/ide_link_pkg.sv ----
// Types shared by both ends of the disk port: modes, commands and states.
// Assumes nothing of its surroundings.
package ide_link_pkg;

    // ============================================================
    // Operating modes of the device
    typedef enum logic [1:0] {MODE_MEMORY, MODE_IO, MODE_IDE} mode_t;

    // ============================================================
    // Host command kinds
    typedef enum logic [1:0] {CMD_REG_READ, CMD_REG_WRITE, CMD_DMA} host_cmd_t;

    // ============================================================
    // State machines
    typedef enum logic [1:0] {D_IDLE, D_WAIT, D_REQ, D_ACK} dev_state_t;
    typedef enum logic [2:0] {
        H_IDLE, H_SETUP, H_STROBE, H_HOLD,
        H_DMA_WAIT, H_DMA_SETUP, H_DMA_STROBE, H_DMA_HOLD
    } host_state_t;

endpackage : ide_link_pkg

// ---- rtl/word_fifo.sv ----
// Small word FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and a single synchronous clock.
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Draining side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_reg_t;

    fifo_reg_t q;
    fifo_reg_t d;
    logic push;
    logic pop;

    // ============================================================
    // Honest flags: full only when every slot holds a word
    assign in_ready = q.cnt != (AW + 1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = q.rp + AW'(1);
        end
        d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : word_fifo

`default_nettype wire
